// *** core/doc_pkg.sv ***
package doc_pkg;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int START_WIN_MS = 60;
  localparam int MEM_DELAY_MS = 40;
  localparam int MEM_MAX_MS = 2500;

  // ****************************************************************
  // Levels, ratios and angles.
  // ****************************************************************
  localparam logic [15:0] U_ARM_LVL = 16'h0050;
  localparam logic [15:0] U_LOW_LVL = 16'h0046;
  localparam int START_LOW_NUM = 12;
  localparam int START_LOW_DEN = 100;
  localparam int START_HIGH_NUM = 3;
  localparam int START_HIGH_DEN = 2;
  localparam int START_END_NUM = 5;
  localparam int START_END_DEN = 4;
  localparam logic signed [10:0] SECTOR_DEG = 11'sh050;
  localparam logic signed [10:0] REVERSE_DEG = 11'sh064;
  localparam logic signed [10:0] HALF_TURN = 11'sh0b4;
  localparam logic signed [10:0] FULL_TURN = 11'sh168;
  localparam logic [15:0] HS_INFINITE = 16'hffff;

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [7:0] SW1_OFS = 8'h00;
  localparam logic [7:0] SW2_OFS = 8'h04;
  localparam logic [7:0] LS_SET_OFS = 8'h08;
  localparam logic [7:0] LS_TIME_OFS = 8'h0c;
  localparam logic [7:0] HS_SET_OFS = 8'h10;
  localparam logic [7:0] HS_TIME_OFS = 8'h14;
  localparam logic [7:0] HS3_TIME_OFS = 8'h18;
  localparam logic [7:0] BASE_OFS = 8'h1c;
  localparam logic [7:0] STATUS_OFS = 8'h20;
  localparam logic [7:0] HS_SHOW_OFS = 8'h24;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int SW1_MODE_LSB = 0;
  localparam int SW1_DOUBLE_BIT = 4;
  localparam int SW1_HS_REV_BIT = 6;
  localparam int SW1_MOD_REV_BIT = 7;
  localparam int SW2_HS_NONDIR_BIT = 0;
  localparam int SW2_HS_OFF_BIT = 4;
  localparam logic [2:0] MODE_DEFINITE = 3'h0;
  localparam logic [2:0] MODE_LAST_CURVE = 3'h6;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] SW1_RST = 8'h00;
  localparam logic [7:0] SW2_RST = 8'h00;
  localparam logic [15:0] LS_SET_RST = 16'h0100;
  localparam logic [15:0] LS_TIME_RST = 16'h03e8;
  localparam logic [15:0] HS_SET_RST = 16'h0400;
  localparam logic [15:0] HS_TIME_RST = 16'h0064;
  localparam logic [15:0] HS3_TIME_RST = 16'h0032;
  localparam logic [9:0] BASE_RST = 10'h3d3;

  typedef enum logic [2:0] {
    MEM_IDLE = 3'b000,
    MEM_ARMED = 3'b001,
    MEM_WAIT = 3'b010,
    MEM_ON = 3'b011,
    MEM_DONE = 3'b100
  } doc_mem_e;

endpackage

// *** core/doc_dir_elem.sv ***
`timescale 1ns/1ps
module doc_dir_elem (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [15:0] volt,
  input wire logic signed [9:0] i_phase,
  input wire logic signed [9:0] u_phase,
  input wire logic signed [9:0] base,
  output logic fwd,
  output logic rev,
  output logic mem_active
);
  import doc_pkg::*;

  typedef struct packed {
    doc_mem_e state;
    logic [11:0] cnt;
    logic signed [9:0] u_mem;
    logic fwd;
    logic rev;
  } doc_elem_s;

  doc_elem_s st_reg;
  doc_elem_s st_next;
  logic signed [10:0] rel;
  logic signed [10:0] mag;
  logic use_mem;

  always_comb begin
    st_next = st_reg;
    use_mem = (st_reg.state == MEM_ON);
    unique case (st_reg.state)
      MEM_IDLE: begin
        if (volt > U_ARM_LVL) begin
          st_next.state = MEM_ARMED;
        end
      end
      MEM_ARMED: begin
        st_next.u_mem = u_phase;
        st_next.cnt = 12'h000;
        if (volt < U_LOW_LVL) begin
          st_next.state = MEM_WAIT;
        end
      end
      MEM_WAIT: begin
        if (volt > U_ARM_LVL) begin
          st_next.state = MEM_ARMED;
        end else if (volt >= U_LOW_LVL) begin
          st_next.cnt = 12'h000;
        end else if (tick) begin
          st_next.cnt = st_reg.cnt + 12'h001;
          if (st_reg.cnt + 12'h001 >= 12'(MEM_DELAY_MS)) begin
            st_next.state = MEM_ON;
            st_next.cnt = 12'h000;
          end
        end
      end
      MEM_ON: begin
        if (volt > U_ARM_LVL) begin
          st_next.state = MEM_ARMED;
        end else if (tick) begin
          st_next.cnt = st_reg.cnt + 12'h001;
          if (st_reg.cnt + 12'h001 >= 12'(MEM_MAX_MS)) begin
            st_next.state = MEM_DONE;
          end
        end
      end
      MEM_DONE: begin
        if (volt > U_ARM_LVL) begin
          st_next.state = MEM_ARMED;
        end
      end
      default: begin
        st_next.state = MEM_IDLE;
      end
    endcase
    // Angle of current against voltage, then against the base angle.
    rel = 11'(i_phase) - 11'(use_mem ? st_reg.u_mem : u_phase) - 11'(base);
    if (rel >= HALF_TURN) begin
      rel = rel - FULL_TURN;
    end
    if (rel >= HALF_TURN) begin
      rel = rel - FULL_TURN;
    end
    if (rel < -HALF_TURN) begin
      rel = rel + FULL_TURN;
    end
    if (rel < -HALF_TURN) begin
      rel = rel + FULL_TURN;
    end
    mag = (rel < 0) ? -rel : rel;
    if ((volt < U_LOW_LVL) && !use_mem) begin
      st_next.fwd = 1'b0;
      st_next.rev = 1'b0;
    end else begin
      st_next.fwd = (mag <= SECTOR_DEG);
      st_next.rev = (mag > REVERSE_DEG);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '{MEM_IDLE, 12'h000, 10'sh000, 1'b0, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign fwd = st_reg.fwd;
  assign rev = st_reg.rev;
  assign mem_active = (st_reg.state == MEM_ON);

endmodule

// *** core/doc_top.sv ***
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Low-set stage runs definite or inverse time.
// - Definite mode uses configured low-set operate time.
// - Inverse mode offers six selectable curves.
// - Low-set starts on overcurrent within sector.
// - Second high-set start replaces inverse timing.
// - High-set stage definite time, directional optional.
// - Switch disables high-set; shows infinite setting.
// - Start situation, collapsed voltages: non-directional high-set trip.
// - Switch doubles high-set threshold during start.
// - Start situation: 0.12 to 1.5 within 60ms.
// - Start situation ends below 1.25 times setting.
// - Two directional elements, opposite voltage polarised.
// - Forward within 80, undetermined to 100, reverse.
// - Switches reverse high-set or whole module direction.
// - Memory armed above 8%, active after 40ms.
// - Memory leaves when voltage rises above 8%.
// - Both memories active requires both phases in sector.
// - Memory lasts at most 2.5 s.
// - Start output on pickup; trip after operate time.
module doc_top #(
  parameter int TICK_CYCLES = doc_pkg::TICK_CYCLES
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] I_A,
  input wire logic [15:0] I_B,
  input wire logic [15:0] U_A,
  input wire logic [15:0] U_B,
  input wire logic signed [9:0] IPH_A,
  input wire logic signed [9:0] IPH_B,
  input wire logic signed [9:0] UPH_A,
  input wire logic signed [9:0] UPH_B,
  input wire logic HS3_START,
  output logic LS_START,
  output logic LS_TRIP,
  output logic HS_START,
  output logic HS_TRIP,
  output logic TRIP_DIR,
  output logic START_SIT,
  output logic [1:0] MEM_ACTIVE
);
  import doc_pkg::*;

  typedef struct packed {
    logic [16:0] tick_cnt;
    logic tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [15:0] ls_set;
    logic [15:0] ls_time;
    logic [15:0] hs_set;
    logic [15:0] hs_time;
    logic [15:0] hs3_time;
    logic [9:0] base;
    logic [5:0] win_cnt;
    logic win_arm;
    logic start_sit;
    logic [15:0] ls_cnt;
    logic [31:0] ls_acc;
    logic [15:0] hs_cnt;
    logic ls_start;
    logic ls_trip;
    logic hs_start;
    logic hs_trip;
    logic trip_dir;
    logic [1:0] mem;
  } doc_top_s;

  doc_top_s st_reg;
  doc_top_s st_next;

  logic [1:0] fwd;
  logic [1:0] rev;
  logic [1:0] mem_on;
  logic [15:0] volt [2];
  logic [15:0] cur [2];
  logic signed [9:0] iph [2];
  logic signed [9:0] uph [2];

  // ****************************************************************
  // Decoding and curve helpers.
  // ****************************************************************
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == SW1_OFS) || (a == SW2_OFS) || (a == LS_SET_OFS)
      || (a == LS_TIME_OFS) || (a == HS_SET_OFS) || (a == HS_TIME_OFS)
      || (a == HS3_TIME_OFS) || (a == BASE_OFS) || (a == STATUS_OFS)
      || (a == HS_SHOW_OFS);
  endfunction

  function automatic logic [31:0] inv_inc(input logic [2:0] curve,
                                          input logic [15:0] excess);
    logic [31:0] e;
    e = {16'h0000, excess};
    unique case (curve)
      3'h1: inv_inc = e;
      3'h2: inv_inc = e << 1;
      3'h3: inv_inc = e << 2;
      3'h4: inv_inc = e << 3;
      3'h5: inv_inc = e >> 1;
      3'h6: inv_inc = e << 4;
      default: inv_inc = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic dir_ok(input logic f, input logic r,
                                  input logic flip);
    dir_ok = flip ? r : f;
  endfunction

  // ****************************************************************
  // Directional elements.
  // ****************************************************************
  assign volt[0] = U_A;
  assign volt[1] = U_B;
  assign cur[0] = I_A;
  assign cur[1] = I_B;
  assign iph[0] = IPH_A;
  assign iph[1] = IPH_B;
  assign uph[0] = UPH_A;
  assign uph[1] = UPH_B;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_elem
      doc_dir_elem u_elem (
        .clk(MCLK),
        .rst(SYS_RST),
        .tick(st_reg.tick),
        .volt(volt[g]),
        .i_phase(iph[g]),
        .u_phase(uph[g]),
        .base(st_reg.base),
        .fwd(fwd[g]),
        .rev(rev[g]),
        .mem_active(mem_on[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Next state.
  // ****************************************************************
  logic [15:0] imax;
  logic [23:0] imax_w;
  logic [23:0] set_w;
  logic [16:0] hs_eff;
  logic [1:0] ls_ok;
  logic [1:0] hs_ok;
  logic ls_pick;
  logic hs_pick;
  logic hs_dir;
  logic both_mem;
  logic low_u;
  logic inverse;
  logic [15:0] excess;
  logic [15:0] hs_show;
  logic wr;
  logic [31:0] rd;

  always_comb begin
    st_next = st_reg;
    imax = (I_A > I_B) ? I_A : I_B;
    imax_w = {8'h00, imax};
    set_w = {8'h00, st_reg.ls_set};
    inverse = (st_reg.sw1[SW1_MODE_LSB +: 3] != MODE_DEFINITE)
      && (st_reg.sw1[SW1_MODE_LSB +: 3] <= MODE_LAST_CURVE);
    both_mem = mem_on[0] & mem_on[1];
    low_u = (U_A < U_LOW_LVL) && (U_B < U_LOW_LVL);

    // Millisecond timebase.
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt >= 17'(TICK_CYCLES - 1)) begin
      st_next.tick_cnt = 17'h00000;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 17'h00001;
    end

    // ****************************************************************
    // Start situation detection.
    // ****************************************************************
    if (imax_w * 24'(START_LOW_DEN) < set_w * 24'(START_LOW_NUM)) begin
      st_next.win_arm = 1'b1;
      st_next.win_cnt = 6'h00;
    end else if (st_reg.win_arm) begin
      if (imax_w * 24'(START_HIGH_DEN) > set_w * 24'(START_HIGH_NUM)) begin
        st_next.start_sit = 1'b1;
        st_next.win_arm = 1'b0;
      end else if (st_reg.tick) begin
        st_next.win_cnt = st_reg.win_cnt + 6'h01;
        if (st_reg.win_cnt + 6'h01 >= 6'(START_WIN_MS)) begin
          st_next.win_arm = 1'b0;
        end
      end
    end
    if (st_reg.start_sit
        && (imax_w * 24'(START_END_DEN) < set_w * 24'(START_END_NUM))) begin
      st_next.start_sit = 1'b0;
    end

    // ****************************************************************
    // Low-set stage.
    // ****************************************************************
    for (int k = 0; k < 2; k++) begin
      ls_ok[k] = dir_ok(fwd[k], rev[k], st_reg.sw1[SW1_MOD_REV_BIT]);
      hs_ok[k] = dir_ok(fwd[k], rev[k],
        st_reg.sw1[SW1_MOD_REV_BIT] ^ st_reg.sw1[SW1_HS_REV_BIT]);
    end
    if (both_mem) begin
      ls_pick = (ls_ok == 2'b11) && (imax > st_reg.ls_set);
    end else begin
      ls_pick = ((I_A > st_reg.ls_set) && ls_ok[0])
        || ((I_B > st_reg.ls_set) && ls_ok[1]);
    end
    excess = (imax > st_reg.ls_set) ? imax - st_reg.ls_set : 16'h0000;
    st_next.ls_start = ls_pick;
    if (!ls_pick) begin
      st_next.ls_cnt = 16'h0000;
      st_next.ls_acc = 32'h0000_0000;
      st_next.ls_trip = 1'b0;
    end else if (st_reg.tick) begin
      st_next.ls_cnt = (st_reg.ls_cnt == 16'hffff) ? st_reg.ls_cnt
        : st_reg.ls_cnt + 16'h0001;
      if (inverse && HS3_START) begin
        st_next.ls_trip = (st_reg.ls_cnt + 16'h0001 >= st_reg.hs3_time);
      end else if (inverse) begin
        st_next.ls_acc = st_reg.ls_acc
          + inv_inc(st_reg.sw1[SW1_MODE_LSB +: 3], excess);
        st_next.ls_trip = (st_next.ls_acc >= {st_reg.ls_time, 16'h0000});
      end else begin
        st_next.ls_trip = (st_reg.ls_cnt + 16'h0001 >= st_reg.ls_time);
      end
    end
    st_next.trip_dir = st_next.ls_trip && (ls_ok == 2'b11);

    // ****************************************************************
    // High-set stage.
    // ****************************************************************
    if (st_reg.sw2[SW2_HS_OFF_BIT]) begin
      hs_eff = 17'h1ffff;
    end else if (st_reg.sw1[SW1_DOUBLE_BIT] && st_reg.start_sit) begin
      hs_eff = {st_reg.hs_set, 1'b0};
    end else begin
      hs_eff = {1'b0, st_reg.hs_set};
    end
    hs_show = st_reg.sw2[SW2_HS_OFF_BIT] ? HS_INFINITE : st_reg.hs_set;
    if (st_reg.sw2[SW2_HS_NONDIR_BIT]) begin
      hs_dir = 1'b1;
    end else if (st_reg.start_sit && low_u) begin
      hs_dir = 1'b1;
    end else if (both_mem) begin
      hs_dir = (hs_ok == 2'b11);
    end else begin
      hs_dir = 1'b0;
    end
    hs_pick = ({1'b0, I_A} > hs_eff && (hs_dir || hs_ok[0]))
      || ({1'b0, I_B} > hs_eff && (hs_dir || hs_ok[1]));
    if (st_reg.sw2[SW2_HS_OFF_BIT] || (both_mem && !hs_dir)) begin
      hs_pick = 1'b0;
    end
    st_next.hs_start = hs_pick;
    if (!hs_pick) begin
      st_next.hs_cnt = 16'h0000;
      st_next.hs_trip = 1'b0;
    end else if (st_reg.tick) begin
      st_next.hs_cnt = (st_reg.hs_cnt == 16'hffff) ? st_reg.hs_cnt
        : st_reg.hs_cnt + 16'h0001;
      st_next.hs_trip = (st_reg.hs_cnt + 16'h0001 >= st_reg.hs_time);
    end
    st_next.mem = mem_on;

    // ****************************************************************
    // Register access.
    // ****************************************************************
    unique case (PADDR)
      SW1_OFS: rd = {24'h000000, st_reg.sw1};
      SW2_OFS: rd = {24'h000000, st_reg.sw2};
      LS_SET_OFS: rd = {16'h0000, st_reg.ls_set};
      LS_TIME_OFS: rd = {16'h0000, st_reg.ls_time};
      HS_SET_OFS: rd = {16'h0000, st_reg.hs_set};
      HS_TIME_OFS: rd = {16'h0000, st_reg.hs_time};
      HS3_TIME_OFS: rd = {16'h0000, st_reg.hs3_time};
      BASE_OFS: rd = {22'h000000, st_reg.base};
      STATUS_OFS: rd = {22'h000000, st_reg.mem, st_reg.start_sit,
        st_reg.trip_dir, st_reg.hs_trip, st_reg.hs_start, st_reg.ls_trip,
        st_reg.ls_start, fwd[1], fwd[0]};
      HS_SHOW_OFS: rd = {16'h0000, hs_show};
      default: rd = 32'h0000_0000;
    endcase
    st_next.pready = PSEL && PENABLE && !st_reg.pready;
    st_next.pslverr = PSEL && PENABLE && !st_reg.pready && !addr_known(PADDR);
    if (PSEL && PENABLE && !st_reg.pready && !PWRITE) begin
      st_next.prdata = rd;
    end
    wr = PSEL && PENABLE && st_reg.pready && PWRITE;
    if (wr) begin
      unique case (PADDR)
        SW1_OFS: st_next.sw1 = PWDATA[7:0];
        SW2_OFS: st_next.sw2 = PWDATA[7:0];
        LS_SET_OFS: st_next.ls_set = PWDATA[15:0];
        LS_TIME_OFS: st_next.ls_time = PWDATA[15:0];
        HS_SET_OFS: st_next.hs_set = PWDATA[15:0];
        HS_TIME_OFS: st_next.hs_time = PWDATA[15:0];
        HS3_TIME_OFS: st_next.hs3_time = PWDATA[15:0];
        BASE_OFS: st_next.base = PWDATA[9:0];
        default: st_next.base = st_reg.base;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_reg <= '0;
      st_reg.sw1 <= SW1_RST;
      st_reg.sw2 <= SW2_RST;
      st_reg.ls_set <= LS_SET_RST;
      st_reg.ls_time <= LS_TIME_RST;
      st_reg.hs_set <= HS_SET_RST;
      st_reg.hs_time <= HS_TIME_RST;
      st_reg.hs3_time <= HS3_TIME_RST;
      st_reg.base <= BASE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign LS_START = st_reg.ls_start;
  assign LS_TRIP = st_reg.ls_trip;
  assign HS_START = st_reg.hs_start;
  assign HS_TRIP = st_reg.hs_trip;
  assign TRIP_DIR = st_reg.trip_dir;
  assign START_SIT = st_reg.start_sit;
  assign MEM_ACTIVE = st_reg.mem;

endmodule

// *** test/doc_top_assertions.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the protection stages.
// ****************************************************************
module doc_top_assertions
  import doc_pkg::*;
#(
  parameter int TICK_CYCLES = doc_pkg::TICK_CYCLES,
  parameter logic [15:0] LS_SET_VAL = doc_pkg::LS_SET_RST
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [15:0] I_A,
  input wire logic [15:0] I_B,
  input wire logic [15:0] U_A,
  input wire logic LS_START,
  input wire logic LS_TRIP,
  input wire logic HS_START,
  input wire logic HS_TRIP,
  input wire logic TRIP_DIR,
  input wire logic START_SIT,
  input wire logic [1:0] MEM_ACTIVE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  logic [15:0] i_max;
  logic [31:0] mem_cnt;
  assign i_max = (I_A > I_B) ? I_A : I_B;
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !MEM_ACTIVE[0]) begin
      mem_cnt <= 32'h0;
    end else begin
      mem_cnt <= mem_cnt + 32'h1;
    end
  end
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_answer;
    PSEL && PENABLE && PREADY;
  endsequence
  AST_APB_ONE_WAIT: assert property (s_access |=> s_answer ##1 !PREADY)
    else $error("APB answer not one cycle after access");
  AST_SLVERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("PSLVERR without PREADY");
  AST_LS_START_CAUSE: assert property (
    $rose(LS_START) |-> $past(i_max) > LS_SET_VAL)
    else $error("Low-set start without overcurrent");
  AST_LS_TRIP_AFTER_START: assert property (
    LS_TRIP |-> $past(LS_START))
    else $error("Low-set trip without start");
  AST_HS_TRIP_AFTER_START: assert property (
    HS_TRIP |-> $past(HS_START))
    else $error("High-set trip without start");
  AST_TRIP_CLEARS: assert property (
    $fell(LS_START) |-> ##[0:1] !LS_TRIP)
    else $error("Trip stays after start dropped");
  AST_TRIP_DIR: assert property (
    TRIP_DIR |-> LS_TRIP || $past(LS_TRIP))
    else $error("Trip direction without low-set trip");
  AST_START_SIT_RISE: assert property (
    $rose(START_SIT) |-> $past(i_max) * 2 > LS_SET_VAL * 3)
    else $error("Start situation below 1.5 times setting");
  AST_START_SIT_END: assert property (
    START_SIT && (i_max * 4 < LS_SET_VAL * 5) |-> ##[1:2] !START_SIT)
    else $error("Start situation kept below 1.25 times setting");
  AST_MEM_ENTRY: assert property (
    $rose(MEM_ACTIVE[0]) |-> $past(U_A, 2) < U_LOW_LVL)
    else $error("Memory entered with voltage present");
  AST_MEM_EXIT: assert property (
    MEM_ACTIVE[0] && (U_A > U_ARM_LVL) |-> ##[1:3] !MEM_ACTIVE[0])
    else $error("Memory kept after voltage returned");
  AST_MEM_LIMIT: assert property (
    mem_cnt <= 2501 * TICK_CYCLES)
    else $error("Memory active too long");
endmodule

bind doc_top doc_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .I_A(I_A), .I_B(I_B), .U_A(U_A),
  .LS_START(LS_START), .LS_TRIP(LS_TRIP), .HS_START(HS_START),
  .HS_TRIP(HS_TRIP), .TRIP_DIR(TRIP_DIR), .START_SIT(START_SIT),
  .MEM_ACTIVE(MEM_ACTIVE));

// *** test/doc_feed.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Source of measured currents, voltages and angles.
// ****************************************************************
module doc_feed (
  input wire logic clk,
  output logic [15:0] i_a,
  output logic [15:0] i_b,
  output logic [15:0] u_a,
  output logic [15:0] u_b,
  output logic signed [9:0] iph_a,
  output logic signed [9:0] iph_b,
  output logic hs3
);
  initial begin
    i_a = 16'h0050;
    i_b = 16'h0050;
    u_a = 16'h03e8;
    u_b = 16'h03e8;
    iph_a = 10'sh3d3;
    iph_b = 10'sh3d3;
    hs3 = 1'b0;
  end
  task automatic set(input logic [15:0] ia, ib, ua, ub,
                     input logic signed [9:0] pa, pb, input logic h);
    @(posedge clk);
    i_a <= ia;
    i_b <= ib;
    u_a <= ua;
    u_b <= ub;
    iph_a <= pa;
    iph_b <= pb;
    hs3 <= h;
  endtask
endmodule

// *** test/doc_top_test.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Register and protection sequences.
// ****************************************************************
module doc_top_test;
  import doc_pkg::*;
  localparam int TK = 10;
  localparam logic signed [9:0] FW = 10'sh3d3;
  localparam logic signed [9:0] RV = 10'sh087;
  localparam logic signed [9:0] MD = 10'sh02d;
  localparam logic [15:0] UN = 16'h03e8;
  localparam logic [15:0] IL = 16'h0050;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ls_start, ls_trip, hs_start, hs_trip;
  logic trip_dir, start_sit, hs3;
  logic [1:0] mem_active;
  logic [15:0] i_a, i_b, u_a, u_b;
  logic signed [9:0] iph_a, iph_b;
  logic signed [9:0] uph = 10'sh000;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  doc_feed feed (.clk(mclk), .i_a(i_a), .i_b(i_b), .u_a(u_a), .u_b(u_b),
    .iph_a(iph_a), .iph_b(iph_b), .hs3(hs3));
  doc_top #(.TICK_CYCLES(TK)) dut (.MCLK(mclk), .SYS_RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .I_A(i_a), .I_B(i_b), .U_A(u_a), .U_B(u_b), .IPH_A(iph_a),
    .IPH_B(iph_b), .UPH_A(uph), .UPH_B(uph), .HS3_START(hs3),
    .LS_START(ls_start), .LS_TRIP(ls_trip), .HS_START(hs_start),
    .HS_TRIP(hs_trip), .TRIP_DIR(trip_dir), .START_SIT(start_sit),
    .MEM_ACTIVE(mem_active));
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic ms(input int n);
    repeat (n * TK) @(posedge mclk);
  endtask
  task automatic see(input logic [3:0] e);
    chk({28'h0, ls_start, ls_trip, hs_start, hs_trip}, {28'h0, e});
  endtask
  initial begin
    static logic [7:0] ofs [8] = '{SW1_OFS, SW2_OFS, LS_SET_OFS, LS_TIME_OFS,
      HS_SET_OFS, HS_TIME_OFS, HS3_TIME_OFS, BASE_OFS};
    static logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h100, 32'h3e8, 32'h400,
      32'h64, 32'h32, 32'h3d3};
    static logic signed [9:0] dph [4] = '{RV, RV, MD, MD};
    logic [31:0] r;
    logic e;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      rd(ofs[k], rv[k]);
    end
    apb(1'b0, 8'h28, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    rd(HS_SHOW_OFS, 32'h400);
    rd(STATUS_OFS, 32'h3);
    wr(SW1_OFS, 32'h7);
    wr(LS_TIME_OFS, 32'h5);
    wr(HS_TIME_OFS, 32'ha);
    feed.set(16'h0200, IL, UN, UN, FW, FW, 1'b0);
    ms(3);
    see(4'b1000);
    ms(4);
    see(4'b1100);
    chk(32'(trip_dir), 32'h1);
    feed.set(IL, IL, UN, UN, FW, FW, 1'b0);
    ms(1);
    see(4'b0000);
    feed.set(16'h0200, IL, UN, UN, FW, FW, 1'b0);
    ms(4);
    feed.set(IL, IL, UN, UN, FW, FW, 1'b0);
    ms(1);
    feed.set(16'h0200, IL, UN, UN, FW, FW, 1'b0);
    ms(4);
    see(4'b1000);
    for (int k = 0; k < 4; k++) begin
      wr(SW1_OFS, k[0] ? 32'h80 : 32'h0);
      feed.set(16'h0200, IL, UN, UN, dph[k], dph[k], 1'b0);
      ms(1);
      chk(32'(ls_start), (k == 1) ? 32'h1 : 32'h0);
    end
    wr(SW1_OFS, 32'h0);
    feed.set(16'h0500, IL, UN, UN, FW, FW, 1'b0);
    ms(6);
    see(4'b1110);
    ms(7);
    see(4'b1111);
    wr(SW1_OFS, 32'h40);
    ms(1);
    see(4'b1100);
    wr(SW1_OFS, 32'h0);
    wr(SW2_OFS, 32'h10);
    rd(HS_SHOW_OFS, 32'hffff);
    chk(32'(hs_start), 32'h0);
    wr(SW2_OFS, 32'h01);
    feed.set(16'h0500, IL, UN, UN, RV, RV, 1'b0);
    ms(1);
    chk(32'(hs_start), 32'h1);
    wr(SW2_OFS, 32'h0);
    wr(SW1_OFS, 32'h10);
    feed.set(16'h0010, 16'h0010, UN, UN, FW, FW, 1'b0);
    ms(1);
    feed.set(16'h0500, 16'h0010, UN, UN, FW, FW, 1'b0);
    ms(2);
    chk(32'(start_sit), 32'h1);
    chk(32'(hs_start), 32'h0);
    feed.set(16'h0900, 16'h0010, UN, UN, FW, FW, 1'b0);
    ms(1);
    chk(32'(hs_start), 32'h1);
    feed.set(16'h0130, 16'h0010, UN, UN, FW, FW, 1'b0);
    ms(1);
    chk(32'(start_sit), 32'h0);
    wr(SW1_OFS, 32'h0);
    feed.set(16'h0010, 16'h0010, UN, UN, RV, RV, 1'b0);
    ms(1);
    feed.set(16'h0500, 16'h0010, 16'h0, 16'h0, RV, RV, 1'b0);
    ms(12);
    chk(32'(hs_trip), 32'h1);
    feed.set(IL, IL, UN, UN, FW, FW, 1'b0);
    ms(1);
    for (int m = 1; m < 7; m++) begin
      wr(SW1_OFS, 32'(m));
      feed.set(16'h0200, IL, UN, UN, FW, FW, 1'b1);
      ms(45);
      chk(32'(ls_trip), 32'h0);
      ms(10);
      chk(32'(ls_trip), 32'h1);
      feed.set(IL, IL, UN, UN, FW, FW, 1'b0);
      ms(1);
    end
    wr(SW1_OFS, 32'h6);
    feed.set(16'h0200, IL, UN, UN, FW, FW, 1'b0);
    ms(75);
    chk(32'(ls_trip), 32'h0);
    ms(10);
    chk(32'(ls_trip), 32'h1);
    wr(SW1_OFS, 32'h0);
    feed.set(IL, IL, 16'h0, UN, FW, FW, 1'b0);
    ms(35);
    chk(32'(mem_active), 32'h0);
    ms(10);
    chk(32'(mem_active), 32'h1);
    uph <= 10'sh0b3;
    feed.set(16'h0200, IL, 16'h0, UN, FW, FW, 1'b0);
    ms(1);
    chk(32'(ls_start), 32'h1);
    uph <= 10'sh000;
    feed.set(IL, IL, UN, UN, FW, FW, 1'b0);
    ms(2);
    chk(32'(mem_active), 32'h0);
    feed.set(IL, IL, 16'h0, UN, FW, FW, 1'b0);
    ms(2520);
    chk(32'(mem_active), 32'h1);
    ms(40);
    chk(32'(mem_active), 32'h0);
    complete_run();
  end
endmodule
